// [logic/power_calc_pkg.sv]
// constants, register map and carrier types of the current and power engine
// assumes one 100 MHz clock domain shared with the register port and front end
package power_calc_pkg;

  // register indices as seen by the register pointer
  localparam logic [7:0] ADDR_CONFIGURATION = 8'h00;
  localparam logic [7:0] ADDR_SHUNT_VOLTAGE_RESULT = 8'h01;
  localparam logic [7:0] ADDR_BUS_VOLTAGE_RESULT = 8'h02;
  localparam logic [7:0] ADDR_POWER_RESULT = 8'h03;
  localparam logic [7:0] ADDR_CURRENT_RESULT = 8'h04;
  localparam logic [7:0] ADDR_SCALE_FACTOR = 8'h05;

  // reset values
  localparam logic [15:0] RST_CONFIGURATION = 16'h0000;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [15:0] RST_SCALE_FACTOR = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // arithmetic constants
  localparam int CURRENT_DIV_SHIFT = 11;
  localparam logic [31:0] CURRENT_ROUND_BIAS = 32'h0000_07ff;
  localparam logic [15:0] POWER_DIVISOR = 16'h4e20;
  localparam int POWER_TO_CURRENT_STEP = 25;
  localparam int BUS_STEP_UV = 1250;
  localparam int BUS_SIGN_BIT = 15;

  // timing: one quotient bit per clock
  localparam int DIVIDE_CYCLES = 32;
  localparam logic [5:0] DIVIDE_LAST = 6'h1f;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] shunt_code;
    logic [15:0] bus_code;
  } meas_t;

  typedef enum logic {
    ST_IDLE,
    ST_DIVIDE
  } calc_state_t;

endpackage : power_calc_pkg

// [logic/current_power_calc_engine.sv]
// current and power engine: result registers plus scale-factor arithmetic
// assumes register port and converter front end run on clk_sys
`timescale 1ns/1ps

module current_power_calc_engine (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire power_calc_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // measurement strobe from the converter front end
  input wire logic meas_valid,
  input wire power_calc_pkg::meas_t meas,
  // status
  output logic scale_written,
  output logic calc_busy
);

  // register storage
  logic [15:0] configuration;
  logic [15:0] shunt_voltage_result;
  logic [15:0] bus_voltage_result;
  logic [15:0] power_result;
  logic [15:0] current_result;
  logic [15:0] scale_factor;

  // divider state
  power_calc_pkg::calc_state_t state;
  logic [31:0] quo;
  logic [15:0] rem;
  logic [5:0] cnt;

  // address decode
  logic hit_cfg;
  logic hit_scale;
  logic wr_cfg;
  logic wr_scale;
  assign hit_cfg = (reg_req.addr == power_calc_pkg::ADDR_CONFIGURATION);
  assign hit_scale = (reg_req.addr == power_calc_pkg::ADDR_SCALE_FACTOR);
  assign wr_cfg = reg_req.wr && hit_cfg;
  assign wr_scale = reg_req.wr && hit_scale;

  logic [15:0] next_rdata;
  always_comb begin
    if (reg_req.addr == power_calc_pkg::ADDR_CONFIGURATION) begin
      next_rdata = configuration;
    end else if (reg_req.addr == power_calc_pkg::ADDR_SHUNT_VOLTAGE_RESULT) begin
      next_rdata = shunt_voltage_result;
    end else if (reg_req.addr == power_calc_pkg::ADDR_BUS_VOLTAGE_RESULT) begin
      next_rdata = bus_voltage_result;
    end else if (reg_req.addr == power_calc_pkg::ADDR_POWER_RESULT) begin
      next_rdata = power_result;
    end else if (reg_req.addr == power_calc_pkg::ADDR_CURRENT_RESULT) begin
      next_rdata = current_result;
    end else if (reg_req.addr == power_calc_pkg::ADDR_SCALE_FACTOR) begin
      next_rdata = scale_factor;
    end else begin
      next_rdata = power_calc_pkg::UNMAPPED_READ;
    end
  end

  // bus code is unsigned with a fixed step; top bit forced low
  logic [15:0] next_bus;
  assign next_bus = {1'b0, meas.bus_code[power_calc_pkg::BUS_SIGN_BIT-1:0]};

  // current: signed shunt times unsigned scale, truncated toward zero
  logic signed [31:0] cur_product;
  logic [31:0] cur_biased;
  logic [31:0] cur_quot;
  logic [15:0] next_current;
  assign cur_product = $signed(meas.shunt_code) * $signed({16'h0000, scale_factor});
  assign cur_biased = cur_product[31] ? (32'(cur_product) + power_calc_pkg::CURRENT_ROUND_BIAS)
                                      : 32'(cur_product);
  assign cur_quot = 32'($signed(cur_biased) >>> power_calc_pkg::CURRENT_DIV_SHIFT);
  assign next_current = cur_quot[15:0];

  // power dividend uses the magnitude of the new current and bus codes
  logic [15:0] cur_mag;
  logic [31:0] pwr_product;
  assign cur_mag = next_current[15] ? 16'(-next_current) : next_current;
  assign pwr_product = cur_mag * next_bus;

  // restoring divider step by the fixed power divisor
  logic [15:0] trial;
  logic take;
  logic [15:0] next_rem;
  logic [31:0] next_quo;
  assign trial = {rem[14:0], quo[31]};
  assign take = (trial >= power_calc_pkg::POWER_DIVISOR);
  assign next_rem = take ? 16'(trial - power_calc_pkg::POWER_DIVISOR) : trial;
  assign next_quo = {quo[30:0], take};

  logic start;
  logic finish;
  assign start = meas_valid && scale_written;
  assign finish = (state == power_calc_pkg::ST_DIVIDE) && (cnt == power_calc_pkg::DIVIDE_LAST);

  // register writes and read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      configuration <= power_calc_pkg::RST_CONFIGURATION;
      scale_factor <= power_calc_pkg::RST_SCALE_FACTOR;
      scale_written <= 1'b0;
      reg_rdata <= power_calc_pkg::UNMAPPED_READ;
    end else begin
      if (wr_cfg) begin
        configuration <= reg_req.wdata;
      end
      if (wr_scale) begin
        scale_factor <= reg_req.wdata;
        scale_written <= 1'b1;
      end
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // measurement capture: only shunt and bus come from outside
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shunt_voltage_result <= power_calc_pkg::RST_RESULT;
      bus_voltage_result <= power_calc_pkg::RST_RESULT;
    end else if (meas_valid) begin
      shunt_voltage_result <= meas.shunt_code;
      bus_voltage_result <= next_bus;
    end
  end

  // current result and power divider; a new measurement restarts the divide
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      current_result <= power_calc_pkg::RST_RESULT;
      power_result <= power_calc_pkg::RST_RESULT;
      state <= power_calc_pkg::ST_IDLE;
      quo <= 32'h0000_0000;
      rem <= 16'h0000;
      cnt <= 6'h00;
      calc_busy <= 1'b0;
    end else if (start) begin
      current_result <= next_current;
      quo <= pwr_product;
      rem <= 16'h0000;
      cnt <= 6'h00;
      state <= power_calc_pkg::ST_DIVIDE;
      calc_busy <= 1'b1;
    end else begin
      case (state)
        power_calc_pkg::ST_IDLE: begin
          calc_busy <= 1'b0;
        end
        power_calc_pkg::ST_DIVIDE: begin
          quo <= next_quo;
          rem <= next_rem;
          cnt <= 6'(cnt + 6'h01);
          if (finish) begin
            power_result <= next_quo[15:0];
            state <= power_calc_pkg::ST_IDLE;
            calc_busy <= 1'b0;
          end
        end
        default: begin
          state <= power_calc_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule : current_power_calc_engine

// [testbench/current_power_calc_engine_sva.sv]
// assertions on the ports of the current and power engine
// assumes one clock domain; bound in below
`timescale 1ns/1ps
module current_power_calc_engine_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port and measurement
  input wire power_calc_pkg::reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic meas_valid,
  input wire power_calc_pkg::meas_t meas,
  // status
  input wire logic scale_written,
  input wire logic calc_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] sf, cur, bus, ac;
  logic signed [32:0] cp, cd;
  wire [31:0] pw = ac * bus / 32'h0000_4e20;
  assign cp = $signed(meas.shunt_code) * $signed({1'b0, sf});
  assign cd = cp / 33'sh800;
  assign ac = cur[15] ? -cur : cur;
  always_ff @(posedge clk_sys) begin
    if (reg_req.wr && reg_req.addr == 8'h05) sf <= reg_req.wdata;
    if (meas_valid) cur <= cd[15:0];
    if (meas_valid) bus <= {1'b0, meas.bus_code[14:0]};
  end
  sequence s_rd(a);
    reg_req.rd && reg_req.addr == a && !meas_valid;
  endsequence
  sequence s_after(a);
    meas_valid ##1 !meas_valid ##1 s_rd(a);
  endsequence
  AST_ZERO: assert property (
    reg_req.rd && !scale_written && reg_req.addr inside {8'h03, 8'h04} |=> reg_rdata == 16'h0000)
    else $error("result not zero");
  AST_SCALE: assert property (
    reg_req.wr && reg_req.addr == 8'h05 |=> scale_written) else $error("scale flag");
  AST_BUSY: assert property (
    meas_valid && scale_written |=> calc_busy) else $error("no start");
  AST_DONE: assert property (
    $fell(calc_busy) |-> $past(meas_valid, 33)) else $error("divide length");
  AST_MSB: assert property (
    s_rd(8'h02) |=> !reg_rdata[15]) else $error("bus top bit");
  AST_SHUNT: assert property (
    s_after(8'h01) |=> reg_rdata == $past(meas.shunt_code, 3)) else $error("shunt");
  AST_CUR: assert property (
    scale_written ##0 s_after(8'h04) |=> reg_rdata == cur) else $error("current");
  AST_PWR: assert property (
    $fell(calc_busy) && !meas_valid ##1 s_rd(8'h03) |=> reg_rdata == pw[15:0])
    else $error("power");
endmodule : current_power_calc_engine_sva
bind current_power_calc_engine current_power_calc_engine_sva u_sva (.clk_sys(clk_sys),
  .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
  .meas(meas), .scale_written(scale_written), .calc_busy(calc_busy));

// [testbench/testbench.sv]
// self-checking bench for the current and power engine
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] sf, sh, bu, cur, pwr;
  } row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  power_calc_pkg::reg_req_t reg_req = '0;
  logic meas_valid = 1'b0;
  power_calc_pkg::meas_t meas = '0;
  logic [15:0] reg_rdata;
  logic scale_written, calc_busy;
  int n_fail = 0;
  int n_checks = 0;
  // scale values of the first two rows follow the software recipe for 1 mA and 2 mohm shunt steps
  row_t rows [4] = '{
    '{16'h0a00, 16'h1f40, 16'h2570, 16'h2710, 16'h12b8},
    '{16'h0a00, 16'he0c0, 16'ha570, 16'hd8f0, 16'h12b8},
    '{16'h03e8, 16'h0003, 16'h7fff, 16'h0001, 16'h0001},
    '{16'h03e8, 16'hfffd, 16'h7fff, 16'hffff, 16'h0001}};
  current_power_calc_engine u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas(meas),
    .scale_written(scale_written), .calc_busy(calc_busy));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 reg_req = '{a, w, !w, d};
    @(posedge clk_sys);
    #1 reg_req = '0;
  endtask : acc
  task rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(reg_rdata, e);
  endtask : rd
  task pulse(input logic [15:0] s, input logic [15:0] b);
    @(posedge clk_sys);
    #1 meas_valid = 1'b1;
    meas = '{s, b};
    @(posedge clk_sys);
    #1 meas_valid = 1'b0;
  endtask : pulse
  task measure(input logic [15:0] s, input logic [15:0] b);
    int i;
    pulse(s, b);
    for (i = 0; i < 40 && calc_busy !== 1'b0; i++) #10;
    if (i == 40) begin
      n_fail++;
      end_sim();
    end
  endtask : measure
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk({15'h0000, scale_written}, 16'h0000);
    pulse(16'h1f40, 16'h2570);
    rd(8'h01, 16'h1f40);
    rd(8'h04, 16'h0000);
    rd(8'h03, 16'h0000);
    acc(1'b1, 8'h00, 16'h4127);
    rd(8'h00, 16'h4127);
    foreach (rows[k]) begin
      acc(1'b1, 8'h05, rows[k].sf);
      rd(8'h05, rows[k].sf);
      measure(rows[k].sh, rows[k].bu);
      rd(8'h03, rows[k].pwr);
      rd(8'h02, rows[k].bu & 16'h7fff);
      rd(8'h04, rows[k].cur);
    end
    // second measurement lands mid-divide, so only its power may appear
    pulse(16'h1f40, 16'h2570);
    rd(8'h04, 16'h0f42);
    measure(16'h0003, 16'h7fff);
    rd(8'h03, 16'h0001);
    acc(1'b1, 8'h04, 16'h1234);
    rd(8'h04, 16'h0001);
    rd(8'h06, 16'h0000);
    // reset in mid-run clears the written flag and the results
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk({15'h0000, scale_written}, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h02, 16'h0000);
    end_sim();
  end
endmodule : testbench
